// ---- rtl/grs_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - one bridge mux per edge clock
// - bridge muxes switch between two sources live
// - x2/x4 receive bypasses the bridge
// - dividers and gearboxes leave reset together
// - sequence needed for x2, x4, 7:1 only
// - halt outputs drive edge clock gates
// - gear resets drive gearboxes and divider
// - gated clocks come from gate outputs
// - two timing-clock cycles between reset and halt edges
// - loopback: receive waits for transmit completion
// - timing clock slower than edge clock
// - halt/reset timing fully built here
module grs_sequencer
    import grs_pkg::*;
(
    input  wire logic      i_clock,      // slower than edge clock
    input  wire logic      i_rst_n,
    input  wire logic      i_seq_req,    // asynchronous reset request
    input  wire grs_gear_t i_rx_gear,
    input  wire grs_gear_t i_tx_gear,
    input  wire logic      i_loopback,
    grs_link_if.sequencer  link,
    output logic           o_busy
);

    // ------------------------------------------------------------
    // request synchroniser
    // ------------------------------------------------------------
    logic req_meta_reg;
    logic req_sync_reg;
    logic req_prev_reg;
    // first stage feeds only the second
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            req_prev_reg <= 1'b0;
        end
        else
        begin
            req_meta_reg <= i_seq_req;
            req_sync_reg <= req_meta_reg;
            req_prev_reg <= req_sync_reg;
        end
    end

    logic start;
    assign start = req_sync_reg & ~req_prev_reg;

    // ------------------------------------------------------------
    // one sequencer per direction
    // ------------------------------------------------------------
    grs_state_t       st_reg   [2];  // 0 = tx, 1 = rx
    grs_state_t       st_next  [2];
    logic [CNT_W-1:0] cnt_reg  [2];
    logic             gap_done [2];
    logic             need     [2];
    logic             go       [2];

    assign need[0] = grs_needs_seq(i_tx_gear);
    assign need[1] = grs_needs_seq(i_rx_gear);
    assign go[0]   = start;
    // the gap ends on the last count; kept out of the next-state process
    // so that the loopback start below forms no combinational loop
    assign gap_done[0] = (cnt_reg[0] == GAP_LAST);
    assign gap_done[1] = (cnt_reg[1] == GAP_LAST);

    // a direction's sequence ends when its last gap runs out
    logic seq_end [2];
    assign seq_end[0] = (st_reg[0] == GRS_ST_RELHALT) && gap_done[0];
    assign seq_end[1] = (st_reg[1] == GRS_ST_RELHALT) && gap_done[1];
    // in loopback rx waits for tx to finish; an x1 tx has nothing to wait for
    assign go[1]   = (i_loopback && need[0]) ? seq_end[0] : start;

    // next-state for both directions
    always_comb
    begin
        for (int d = 0; d < 2; d++)
        begin
            st_next[d]  = st_reg[d];
            case (st_reg[d])
                GRS_ST_IDLE:
                    if (go[d] && need[d])
                        st_next[d] = GRS_ST_RST;
                GRS_ST_RST:
                    if (gap_done[d])
                        st_next[d] = GRS_ST_HALT;
                GRS_ST_HALT:
                    if (gap_done[d])
                        st_next[d] = GRS_ST_RELRST;
                GRS_ST_RELRST:
                    if (gap_done[d])
                        st_next[d] = GRS_ST_RELHALT;
                GRS_ST_RELHALT:
                    if (gap_done[d])
                        st_next[d] = GRS_ST_IDLE;
                default:
                    st_next[d] = GRS_ST_IDLE;
            endcase
        end
    end

    // state and gap counters; counter restarts on every edge change
    always_ff @(posedge i_clock)
    begin
        for (int d = 0; d < 2; d++)
        begin
            if (!i_rst_n)
            begin
                st_reg[d]  <= GRS_ST_IDLE;
                cnt_reg[d] <= CNT_ZERO;
            end
            else
            begin
                st_reg[d] <= st_next[d];
                if (st_next[d] != st_reg[d] || st_reg[d] == GRS_ST_IDLE)
                    cnt_reg[d] <= CNT_ZERO;
                else
                    cnt_reg[d] <= cnt_reg[d] + CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // outputs, registered except o_busy; halt and reset never move together
    // ------------------------------------------------------------
    logic tx_rst_reg, tx_halt_reg, rx_rst_reg, rx_halt_reg;
    logic tx_done_reg, rx_done_reg;

    function automatic logic in_rst(input grs_state_t s);
        return s == GRS_ST_RST || s == GRS_ST_HALT;
    endfunction
    function automatic logic in_halt(input grs_state_t s);
        return s == GRS_ST_HALT || s == GRS_ST_RELRST;
    endfunction
    // reset stays up after power-on until a sequence takes it over
    function automatic logic rst_next(input logic needed, input grs_state_t s_next, input logic rst_now,
                                      input logic done_now, input logic start_now);
        return needed & (in_rst(s_next) | (rst_now & ~done_now & (s_next == GRS_ST_IDLE) & ~start_now));
    endfunction

    // gearing resets; x1 gearing skips the sequence, so reset just drops
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            tx_rst_reg <= 1'b1;   // hold gearing in reset until sequenced
            rx_rst_reg <= 1'b1;
        end
        else
        begin
            tx_rst_reg <= rst_next(need[0], st_next[0], tx_rst_reg, tx_done_reg, go[0]);
            rx_rst_reg <= rst_next(need[1], st_next[1], rx_rst_reg, rx_done_reg, go[1]);
        end
    end

    // halts trail the reset by one phase at each end
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            tx_halt_reg <= 1'b0;
            rx_halt_reg <= 1'b0;
        end
        else
        begin
            tx_halt_reg <= in_halt(st_next[0]);
            rx_halt_reg <= in_halt(st_next[1]);
        end
    end

    // done flags: a new start clears them before the end can set them
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            tx_done_reg <= 1'b0;
            rx_done_reg <= 1'b0;
        end
        else
        begin
            if (go[0])
                tx_done_reg <= 1'b0;
            else if (seq_end[0] || !need[0])
                tx_done_reg <= 1'b1;
            if (go[1])
                rx_done_reg <= 1'b0;
            else if (seq_end[1] || !need[1])
                rx_done_reg <= 1'b1;
        end
    end

    assign link.tx_gear_rst = tx_rst_reg;
    assign link.rx_gear_rst = rx_rst_reg;
    assign link.tx_halt     = tx_halt_reg;
    assign link.rx_halt     = rx_halt_reg;
    assign link.tx_done     = tx_done_reg;
    assign link.rx_done     = rx_done_reg;
    assign o_busy = (st_reg[0] != GRS_ST_IDLE) | (st_reg[1] != GRS_ST_IDLE);

endmodule // grs_sequencer
`default_nettype wire

// ---- rtl/grs_pkg.sv ----
package grs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 40;
    // spacing between reset/halt edges, in fast edge-clock cycles
    localparam int unsigned MIN_GAP_FAST   = 2;
    // timing clock is slower than the edge clock, so one slow cycle
    // already covers more than one fast cycle; keep margin anyway
    localparam int unsigned GAP_CYCLES     = MIN_GAP_FAST;
    localparam int unsigned CNT_W          = 4;
    localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(GAP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;

    // ------------------------------------------------------------
    // gearing modes
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        GRS_GEAR_X1  = 2'h0,
        GRS_GEAR_X2  = 2'h1,
        GRS_GEAR_X4  = 2'h2,
        GRS_GEAR_71  = 2'h3
    } grs_gear_t;

    // sequencer states, gray from IDLE up to RELHALT; the step from RELHALT back to IDLE flips two bits
    typedef enum logic [2:0]
    {
        GRS_ST_IDLE    = 3'h0,
        GRS_ST_RST     = 3'h1,
        GRS_ST_HALT    = 3'h3,
        GRS_ST_RELRST  = 3'h2,
        GRS_ST_RELHALT = 3'h6,
        GRS_ST_TXWAIT  = 3'h7
    } grs_state_t;

    // true when the gearing needs the halt/reset sequence
    function automatic logic grs_needs_seq(input grs_gear_t g);
        return g != GRS_GEAR_X1;
    endfunction

endpackage

// ---- rtl/grs_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface grs_link_if;
    logic rx_halt;        // to rx edge_clock_gate_sync halt
    logic tx_halt;        // to tx edge_clock_gate_sync halt
    logic rx_gear_rst;    // to rx gearboxes and clock_divider_unit
    logic tx_gear_rst;    // to tx gearboxes and clock_divider_unit
    logic tx_done;        // tx sequence finished
    logic rx_done;        // rx sequence finished

    modport sequencer (output rx_halt, tx_halt, rx_gear_rst, tx_gear_rst, tx_done, rx_done);
    modport gearing   (input rx_halt, tx_halt, rx_gear_rst, tx_gear_rst, tx_done, rx_done);
endinterface
`default_nettype wire

// ---- rtl/grs_gearing_end.sv ----
`timescale 1ns/1ns
`default_nettype none
// gearing-side end: edge clock gates, bridge muxes, reset fan-out
module grs_gearing_end
    import grs_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    grs_link_if.gearing     link,
    input  wire logic [1:0] i_fast_clk_a,     // candidate fast edge clocks, per edge clock
    input  wire logic [1:0] i_fast_clk_b,
    input  wire logic [1:0] i_bridge_sel,     // run-time bridge selection
    input  wire logic       i_rx_is_x2x4,     // rx uses x2/x4 gearing
    output logic            o_rx_gated_edge_clock,
    output logic            o_tx_gated_edge_clock,
    output logic            o_rx_gear_rst,
    output logic            o_tx_gear_rst,
    output logic            o_ready
);

    // ------------------------------------------------------------
    // bridge muxes
    // ------------------------------------------------------------
    logic [1:0] bridge_clk;
    // one mux per edge clock on this side
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            bridge_clk[i] = i_bridge_sel[i] ? i_fast_clk_b[i] : i_fast_clk_a[i];
        end
    end

    // ------------------------------------------------------------
    // gates and reset fan-out
    // ------------------------------------------------------------
    // x2/x4 receive never goes through the bridge: it takes the raw source
    logic rx_src;
    assign rx_src = i_rx_is_x2x4 ? i_fast_clk_a[0] : bridge_clk[0];

    // gated clocks come only from the gate outputs
    assign o_rx_gated_edge_clock = rx_src & ~link.rx_halt;
    assign o_tx_gated_edge_clock = bridge_clk[1] & ~link.tx_halt;
    assign o_rx_gear_rst         = link.rx_gear_rst;
    assign o_tx_gear_rst         = link.tx_gear_rst;

    // ready flag registered, both directions out of sequence
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            o_ready <= 1'b0;
        else
            o_ready <= link.tx_done & link.rx_done;
    end

endmodule // grs_gearing_end
`default_nettype wire

// ---- verif/grs_link_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// link checker: halt/reset spacing and order on both directions
// ------------------------------------------------------------
module grs_link_chk
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_tx_halt,
    input wire logic i_rx_halt,
    input wire logic i_tx_gear_rst,
    input wire logic i_rx_gear_rst,
    input wire logic i_tx_done,
    input wire logic i_rx_done
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // halt phase: two cycles with reset, two after its release
    sequence s_hold(h, r); (r && h)[*2] ##1 (!r && h)[*2]; endsequence
    sequence s_tail(h, d); !h ##2 d; endsequence

    property p_tx_order;
        $rose(i_tx_halt) |-> s_hold(i_tx_halt, i_tx_gear_rst) ##1 s_tail(i_tx_halt, i_tx_done);
    endproperty
    a_tx_order: assert property (p_tx_order) else $error("tx step order wrong");
    property p_rx_order;
        $rose(i_rx_halt) |-> s_hold(i_rx_halt, i_rx_gear_rst) ##1 s_tail(i_rx_halt, i_rx_done);
    endproperty
    a_rx_order: assert property (p_rx_order) else $error("rx step order wrong");
    // reset must already have stood two cycles when the halt comes
    property p_tx_lead; $rose(i_tx_halt) |-> $past(i_tx_gear_rst) && $past(i_tx_gear_rst, 2); endproperty
    a_tx_lead: assert property (p_tx_lead) else $error("tx halt too soon");
    property p_rx_lead; $rose(i_rx_halt) |-> $past(i_rx_gear_rst) && $past(i_rx_gear_rst, 2); endproperty
    a_rx_lead: assert property (p_rx_lead) else $error("rx halt too soon");
    property p_tx_fall; $fell(i_tx_halt) |-> !$past(i_tx_gear_rst) && !$past(i_tx_gear_rst, 2); endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("tx halt released early");
    property p_rx_fall; $fell(i_rx_halt) |-> !$past(i_rx_gear_rst) && !$past(i_rx_gear_rst, 2); endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("rx halt released early");
    property p_tx_done; $rose(i_tx_done) |-> !i_tx_halt && !i_tx_gear_rst; endproperty
    a_tx_done: assert property (p_tx_done) else $error("tx done while active");
    property p_rx_done; $rose(i_rx_done) |-> !i_rx_halt && !i_rx_gear_rst; endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx done while active");
    // rx may only start alone once tx has finished
    property p_loop; $rose(i_rx_halt) |-> i_tx_done || $rose(i_tx_halt); endproperty
    a_loop: assert property (p_loop) else $error("rx started before tx end");
endmodule // grs_link_chk
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench
    import grs_pkg::*;
;
    logic       i_clock = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       i_seq_req = 1'b0;
    logic       i_loopback = 1'b0;
    logic       rx_x2x4 = 1'b0;
    grs_gear_t  i_rx_gear = GRS_GEAR_X2;
    grs_gear_t  i_tx_gear = GRS_GEAR_X2;
    logic [1:0] fast_a = 2'h0;
    logic [1:0] fast_b = 2'h3;
    logic [1:0] bsel = 2'h3;   // bridge on b, so both gates see a steady high
    logic       busy, rxg, txg, rx_rst, tx_rst, ready;
    int         fail_count = 0;
    int         checks_done = 0;

    // ------------------------------------------------------------
    // clock and the two ends
    // ------------------------------------------------------------
    always #(CLK_PERIOD_NS / 2) i_clock = ~i_clock;
    grs_link_if link ();
    grs_sequencer grs_sequencer_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_seq_req(i_seq_req),
        .i_rx_gear(i_rx_gear), .i_tx_gear(i_tx_gear), .i_loopback(i_loopback), .link(link), .o_busy(busy));
    grs_gearing_end grs_gearing_end_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(link),
        .i_fast_clk_a(fast_a), .i_fast_clk_b(fast_b), .i_bridge_sel(bsel), .i_rx_is_x2x4(rx_x2x4),
        .o_rx_gated_edge_clock(rxg), .o_tx_gated_edge_clock(txg), .o_rx_gear_rst(rx_rst),
        .o_tx_gear_rst(tx_rst), .o_ready(ready));
    grs_link_chk grs_link_chk_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_tx_halt(link.tx_halt),
        .i_rx_halt(link.rx_halt), .i_tx_gear_rst(link.tx_gear_rst), .i_rx_gear_rst(link.rx_gear_rst),
        .i_tx_done(link.tx_done), .i_rx_done(link.rx_done));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
            fail_count++;
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one request, watched for a fixed window long enough for loopback
    task run_seq(input grs_gear_t tg, input grs_gear_t rg, input logic lb);
        int nt, nr, nov, et, er;
        nt = 0;
        nr = 0;
        nov = 0;
        et = (tg != GRS_GEAR_X1) ? 2 * GAP_CYCLES : 0;
        er = (rg != GRS_GEAR_X1) ? 2 * GAP_CYCLES : 0;
        @(negedge i_clock);
        i_tx_gear = tg;
        i_rx_gear = rg;
        i_loopback = lb;
        i_seq_req = 1'b1;
        repeat (30)
        begin
            @(negedge i_clock);
            nt += link.tx_halt;
            nr += link.rx_halt;
            nov += link.tx_halt & link.rx_halt;
            chk("tx reset fan-out", link.tx_gear_rst, tx_rst);
            chk("rx reset fan-out", link.rx_gear_rst, rx_rst);
            chk("tx gate stopped", ~link.tx_halt, txg);
            chk("rx gate stopped", ~link.rx_halt, rxg);
        end
        i_seq_req = 1'b0;
        chk("tx halt length", 1'b1, nt == et);
        chk("rx halt length", 1'b1, nr == er);
        chk("halt overlap", 1'b1, nov == ((lb || et == 0) ? 0 : er));
        chk("busy ended", 1'b0, busy);
        chk("tx done", 1'b1, link.tx_done);
        chk("rx done", 1'b1, link.rx_done);
        chk("tx reset off", 1'b0, link.tx_gear_rst);
        chk("ready", 1'b1, ready);
        repeat (4) @(negedge i_clock);
    endtask

    task br(input logic [1:0] a, input logic [1:0] b, input logic [1:0] s, input logic x,
            input logic et, input logic er);
        @(negedge i_clock);
        fast_a = a;
        fast_b = b;
        bsel = s;
        rx_x2x4 = x;
        #1;
        chk("tx gated clock", et, txg);
        chk("rx gated clock", er, rxg);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge i_clock);
        i_rst_n = 1'b1;
        @(negedge i_clock);
        chk("tx reset held", 1'b1, link.tx_gear_rst);
        chk("tx halt idle", 1'b0, link.tx_halt);
        run_seq(GRS_GEAR_X2, GRS_GEAR_X4, 1'b0);
        run_seq(GRS_GEAR_71, GRS_GEAR_X1, 1'b0);
        run_seq(GRS_GEAR_X4, GRS_GEAR_71, 1'b1);
        run_seq(GRS_GEAR_X1, GRS_GEAR_X2, 1'b1);
        run_seq(GRS_GEAR_X1, GRS_GEAR_X1, 1'b0);
        br(2'h0, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0);
        br(2'h0, 2'h3, 2'h3, 1'b0, 1'b1, 1'b1);
        br(2'h1, 2'h0, 2'h3, 1'b1, 1'b0, 1'b1);
        br(2'h0, 2'h3, 2'h3, 1'b1, 1'b1, 1'b0);
        @(negedge i_clock);
        rx_x2x4 = 1'b0;
        bsel = 2'h1;
        #1;
        chk("one mux per clock", 1'b1, txg ^ rxg);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
